// *** tb/serializer_input_coding_config_bench.sv ***
// self-checking bench for the input format and coding block
`timescale 1ns/1ps
`default_nettype none
module serializer_input_coding_config_bench;
    logic clk_i, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, dat_o;
    logic [5:0] strap = 6'h0, check_o;
    logic cfh = 1'b0, ack_o, pclk, word_valid_o, bw, hv, iv, ih, e;
    logic [33:0] src_a = 34'h0, src_b = 34'h0, bus, word_o;
    logic [3:0] slot;
    logic [1:0] c;
    logic [39:0] wq[$];
    logic [31:0] rq[$];
    integer seed = 32'h31b5_5da1, n_mismatch = 0, n_compared = 0, i, n;
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    sicc_pixel_src i_src (.clk_i(clk_i), .go_i(go), .a_i(src_a), .b_i(src_b), .pclk_o(pclk), .bus_o(bus));
    sicc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .config_link_enable_pin(strap[5]),
        .width_strap_pin(strap[4]), .sync_strap_pin(strap[3]), .coding_strap_pin(strap[2]),
        .double_strap_pin(strap[1]), .config_pin_high(cfh), .config_pin_low(strap[0]),
        .pixel_clock_input(pclk), .parallel_input_i(bus[31:0]), .horizontal_sync_i(bus[32]),
        .vertical_sync_i(bus[33]), .double_input_mode_o(), .low_rate_o(), .bus_width_select_o(),
        .capture_edge_select_o(), .sync_encoding_enable_o(), .error_coding_select_o(), .word_o(word_o),
        .check_o(check_o), .interleave_slot_o(slot), .word_valid_o(word_valid_o));
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_word(input logic [43:0] got, input logic [43:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (wq.size() != 0 || rq.size() != 0) n_mismatch++;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // one classic cycle; a read notes its expected byte
    task automatic wb(input logic [7:0] a, input logic w, input logic [7:0] d, input logic s, input logic [7:0] x);
        if (!w) rq.push_back({24'h00_0000, x});
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        sel <= {3'($random(seed)), s};
        dat <= {24'($random(seed)), d};
        do @(posedge clk_i);
        while (ack_o !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    function automatic logic [33:0] exp_word(input logic [33:0] w);
        if (!bw) w[31:24] = 8'h00;
        if (hv) w[33:32] = w[33:32] ^ {iv, ih};
        else begin
            w[33:32] = 2'h0;
            w[1:0] = w[1:0] ^ {ih, iv};
        end
        return w;
    endfunction
    // expected check bits: parity, crc x^6+x+1 msb first, hamming positions from 3
    function automatic logic [5:0] exp_chk(input logic [1:0] m, input logic [33:0] w);
        logic [5:0] r;
        logic [6:0] p;
        r = 6'h00;
        p = 7'h02;
        if (m == 2'h0) return {5'h00, ^w};
        for (int j = 0; j < 34; j++) begin
            if (m == 2'h1) r = {r[4:0], 1'b0} ^ ((r[5] ^ w[33 - j]) ? 6'h03 : 6'h00);
            else begin
                p++;
                if ((p & (p - 7'h01)) == 7'h00) p++;
                if (w[j]) r = r ^ p[5:0];
            end
        end
        return r;
    endfunction
    // monitors take the oldest note whenever a result appears
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && !we) cmp_reg(dat_o, rq.size() ? rq.pop_front() : 32'hDEAD_BEEF);
        if (word_valid_o === 1'b1) begin
            logic [39:0] x;
            x = wq.size() ? wq.pop_front() : 40'h0;
            cmp_word({slot, check_o, word_o},
                {x[39:36], exp_chk(x[35:34], x[33:0]), x[33:0]});
        end
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        for (i = 0; i < 4; i++) begin
            strap <= i == 0 ? 6'h1F : i == 1 ? 6'h3E : 6'($random(seed));
            cfh <= 1'($random(seed));
            rst_i <= 1'b1;
            repeat (5) @(posedge clk_i);
            rst_i <= 1'b0;
            @(posedge clk_i);
            bw = ~strap[5] & strap[4];
            wb(8'h1C, 1'b0, 8'h00, 1'b1, {~strap[5] & strap[1], 1'b0, bw, strap[0], 1'b0,
                ~strap[5] & strap[3], ~strap[5] & strap[2], 1'b0});
            wb(8'h20, 1'b0, 8'h00, 1'b1, 8'h00);
        end
        wb(8'h1C, 1'b1, 8'h02, 1'b1, 8'h00);
        wb(8'h1C, 1'b1, 8'hFF, 1'b1, 8'h00);
        wb(8'h1C, 1'b0, 8'h00, 1'b1, 8'hF6);
        wb(8'h20, 1'b1, 8'hFF, 1'b1, 8'h00);
        wb(8'h20, 1'b1, 8'h00, 1'b0, 8'h00);
        wb(8'h20, 1'b0, 8'h00, 1'b1, 8'hC0);
        wb(8'h00, 1'b1, 8'hFF, 1'b1, 8'h00);
        wb(8'h00, 1'b0, 8'h00, 1'b1, 8'h00);
        for (i = 0; i < 24; i++) begin
            c = 2'(i % 3);
            hv = 1'((i / 3) % 2);
            bw = 1'((i / 6) % 2);
            e = 1'(i / 12);
            {iv, ih} = 2'($random(seed));
            // pixel clock is stopped here; double mode set, though inversion applies in either mode
            wb(8'h1C, 1'b1, {2'h2, bw, e, 1'b0, hv, c}, 1'b1, 8'h00);
            wb(8'h20, 1'b1, {iv, ih, 6'h00}, 1'b1, 8'h00);
            n = 0;
            repeat (3) begin
                src_a <= 34'({$random(seed), $random(seed)});
                src_b <= 34'({$random(seed), $random(seed)});
                go <= 1'b1;
                @(posedge clk_i);
                go <= 1'b0;
                wq.push_back({c == 2'h2 ? 4'(n) : 4'h0, c, exp_word(e ? src_b : src_a)});
                n++;
                repeat (24) @(posedge clk_i);
            end
        end
        repeat (4) @(posedge clk_i);
        tally_and_finish;
    end
endmodule
`default_nettype wire

// *** tb/sicc_pixel_src.sv ***
// parallel pixel source: one pixel clock period per request
`timescale 1ns/1ps
`default_nettype none
module sicc_pixel_src (
    input  wire logic        clk_i,  // bench clock
    input  wire logic        go_i,   // start one period
    input  wire logic [33:0] a_i,    // word around rising edge
    input  wire logic [33:0] b_i,    // word around falling edge
    output var  logic        pclk_o, // pixel clock, low when idle
    output var  logic [33:0] bus_o   // {vs, hs, data}
);
    logic [3:0] cnt  = 4'h0;
    logic       busy = 1'b0;
    initial pclk_o = 1'b0;
    initial bus_o = 34'h0;
    // each word is held four cycles either side of its edge
    always @(posedge clk_i) begin
        if (go_i && !busy) begin
            busy  <= 1'b1;
            cnt   <= 4'h0;
            bus_o <= a_i;
        end else if (busy) begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'h3) pclk_o <= 1'b1;
            if (cnt == 4'h7) bus_o <= b_i;
            if (cnt == 4'hB) pclk_o <= 1'b0;
            if (cnt == 4'hF) begin
                bus_o <= ~b_i;
                busy  <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/sicc_top_asserts.sv ***
// port assertions for the input format and coding block
`timescale 1ns/1ps
`default_nettype none
module sicc_top_asserts #(
    parameter DATA_W = 32
) (
    input wire logic              clk_i,                  // clock
    input wire logic              rst_i,                  // reset
    input wire logic              cyc_i,                  // cycle
    input wire logic              stb_i,                  // strobe
    input wire logic              we_i,                   // write
    input wire logic [7:0]        adr_i,                  // address
    input wire logic [3:0]        sel_i,                  // selects
    input wire logic [31:0]       dat_i,                  // write data
    input wire logic [31:0]       dat_o,                  // read data
    input wire logic              ack_o,                  // ack
    input wire logic              config_link_enable_pin, // override
    input wire logic              width_strap_pin,        // width strap
    input wire logic              sync_strap_pin,         // sync strap
    input wire logic              coding_strap_pin,       // coding strap
    input wire logic              double_strap_pin,       // double strap
    input wire logic              config_pin_low,         // config 0
    input wire logic              pixel_clock_input,      // pixel clock
    input wire logic              double_input_mode_o,    // double mode
    input wire logic              bus_width_select_o,     // width
    input wire logic              capture_edge_select_o,  // edge
    input wire logic              sync_encoding_enable_o, // sync enc
    input wire logic [1:0]        error_coding_select_o,  // coding
    input wire logic [DATA_W+1:0] word_o,                 // word
    input wire logic [5:0]        check_o,                // check bits
    input wire logic [3:0]        interleave_slot_o,      // slot
    input wire logic              word_valid_o            // valid
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
        else $error("ack not one cycle after request");
    AST_CODING_KEEP: assert property (cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i[5:2] == 4'h7
        && dat_i[1:0] == 2'h3 |=> $stable(error_coding_select_o)) else $error("coding 11 accepted");
    AST_HIGH_ZERO: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
        else $error("read upper bits not zero");
    AST_STRAP_DEF: assert property ($fell(rst_i) |-> capture_edge_select_o == config_pin_low
        && bus_width_select_o == (!config_link_enable_pin && width_strap_pin)
        && sync_encoding_enable_o == (!config_link_enable_pin && sync_strap_pin)
        && double_input_mode_o == (!config_link_enable_pin && double_strap_pin)) else $error("strap default wrong");
    AST_CODING_DEF: assert property ($fell(rst_i) |-> error_coding_select_o
        == {!config_link_enable_pin && coding_strap_pin, 1'b0}) else $error("coding default wrong");
    AST_NARROW: assert property (word_valid_o && !bus_width_select_o |-> word_o[31:24] == 8'h00)
        else $error("narrow mode passed top byte");
    AST_NO_SYNC: assert property (word_valid_o && !sync_encoding_enable_o |-> word_o[33:32] == 2'h0)
        else $error("sync bits present while disabled");
    AST_PARITY: assert property (word_valid_o && error_coding_select_o == 2'h0 |-> check_o[0] == ^word_o)
        else $error("parity bit wrong");
    AST_SLOT_ZERO: assert property (word_valid_o && error_coding_select_o != 2'h2 |-> interleave_slot_o == 4'h0)
        else $error("slot moves outside hamming mode");
    AST_RISE_CAP: assert property ($rose(pixel_clock_input) && !capture_edge_select_o |-> ##[2:5] word_valid_o)
        else $error("no capture after rising edge");
    AST_FALL_CAP: assert property ($fell(pixel_clock_input) && capture_edge_select_o |-> ##[2:5] word_valid_o)
        else $error("no capture after falling edge");
endmodule
bind sicc_top sicc_top_asserts #(.DATA_W(DATA_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .config_link_enable_pin(config_link_enable_pin), .width_strap_pin(width_strap_pin),
    .sync_strap_pin(sync_strap_pin), .coding_strap_pin(coding_strap_pin), .double_strap_pin(double_strap_pin),
    .config_pin_low(config_pin_low), .pixel_clock_input(pixel_clock_input),
    .double_input_mode_o(double_input_mode_o), .bus_width_select_o(bus_width_select_o),
    .capture_edge_select_o(capture_edge_select_o), .sync_encoding_enable_o(sync_encoding_enable_o),
    .error_coding_select_o(error_coding_select_o), .word_o(word_o), .check_o(check_o),
    .interleave_slot_o(interleave_slot_o), .word_valid_o(word_valid_o));
`default_nettype wire

// *** verilog/sicc_check_gen.v ***
// check-bit generator: parity, crc and hamming over one input word
`timescale 1ns/1ps
`default_nettype none
`include "sicc_defs.vh"

module sicc_check_gen #(
    parameter WIDTH = 34
) (
    input  wire [WIDTH-1:0] word_i,  // word to protect
    input  wire [1:0]       mode_i,  // error coding select
    output reg  [5:0]       check_o  // check bits, bit 0 used for parity
);

    reg [5:0] crc;
    reg [5:0] ham;
    reg       fb;
    reg [6:0] pos;
    integer   i;
    integer   k;

    always @* begin
        crc = 6'h00;
        ham = 6'h00;
        fb  = 1'b0;
        pos = 7'h00;
        // ------------------------------------------------------------
        // serial crc, msb first
        // ------------------------------------------------------------
        for (i = WIDTH - 1; i >= 0; i = i - 1) begin
            fb  = crc[5] ^ word_i[i];
            crc = {crc[4:0], 1'b0} ^ (fb ? `SICC_CRC_POLY : 6'h00);
        end
        // ------------------------------------------------------------
        // hamming: data bits take the non-power-of-two code positions
        // ------------------------------------------------------------
        for (i = 0; i < WIDTH; i = i + 1) begin
            pos = pos + 7'h01;
            if ((pos & (pos - 7'h01)) == 7'h00) begin
                pos = pos + 7'h01;
            end
            if ((pos & (pos - 7'h01)) == 7'h00) begin
                pos = pos + 7'h01;
            end
            for (k = 0; k < 6; k = k + 1) begin
                if (pos[k]) begin
                    ham[k] = ham[k] ^ word_i[i];
                end
            end
        end
        case (mode_i)
            `SICC_CODE_CRC: begin
                check_o = crc;
            end
            `SICC_CODE_HAMMING: begin
                check_o = ham;
            end
            default: begin
                check_o = {5'h00, ^word_i};
            end
        endcase
    end

endmodule

`default_nettype wire

// *** verilog/sicc_defs.vh ***
// register map, field positions, reset values and coding constants
`ifndef SICC_DEFS_VH
`define SICC_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------
`define SICC_IDX_FMT        4'h7
`define SICC_IDX_INV        4'h8
`define SICC_ADR_MSB        5
`define SICC_ADR_LSB        2

// ----------------------------------------------------------------
// format and coding control fields
// ----------------------------------------------------------------
`define SICC_FMT_DUAL_BIT   7
`define SICC_FMT_RATE_BIT   6
`define SICC_FMT_WIDE_BIT   5
`define SICC_FMT_EDGE_BIT   4
`define SICC_FMT_SENC_BIT   2
`define SICC_FMT_CODE_MSB   1
`define SICC_FMT_CODE_LSB   0

// ----------------------------------------------------------------
// sync inversion control fields
// ----------------------------------------------------------------
`define SICC_INV_VSYNC_BIT  7
`define SICC_INV_HSYNC_BIT  6

// ----------------------------------------------------------------
// reset values and coding encodings
// ----------------------------------------------------------------
`define SICC_INV_RESET      8'h00
`define SICC_RATE_RESET     1'b0
`define SICC_CODE_PARITY    2'h0
`define SICC_CODE_CRC       2'h1
`define SICC_CODE_HAMMING   2'h2
`define SICC_CODE_UNUSED    2'h3
`define SICC_CRC_POLY       6'h03
`define SICC_ILV_WORDS      16

`endif

// *** verilog/sicc_pin_sync.v ***
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module sicc_pin_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_i,   // system clock
    input  wire [WIDTH-1:0] pin_i,   // asynchronous pins
    output wire [WIDTH-1:0] sync_o   // synchronised levels
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // ------------------------------------------------------------
    // one two-flop chain per bit
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            always @(posedge clk_i) begin
                meta_reg[gi] <= pin_i[gi];
                sync_reg[gi] <= meta_reg[gi];
            end
        end
    endgenerate

    assign sync_o = sync_reg;

endmodule

`default_nettype wire

// *** verilog/sicc_top.v ***
// serializer input format and coding configuration with pixel capture
//
// How it works
// - bus width 1 selects 32-bit input
// - edge select 0 captures on rising
// - edge select 1 captures on falling
// - edge select reset comes from config input 0
// - sync enable 0 disables sync encoding
// - sync enable 1 applies sync encoding
// - coding 00 uses single parity bit
// - coding 01 appends six-bit crc
// - coding 10 hamming with 16-word interleave
// - vertical invert flips vsync or bit zero
// - horizontal invert flips hsync or bit one
// - input mode only drives double_input_mode_o; capture takes one edge in either mode
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "sicc_defs.vh"

module sicc_top #(
    parameter DATA_W = 32
) (
    input  wire              clk_i,                  // 25 MHz system clock
    input  wire              rst_i,                  // synchronous reset, high
    // wishbone slave
    input  wire              cyc_i,                  // bus cycle
    input  wire              stb_i,                  // strobe
    input  wire              we_i,                   // write enable
    input  wire [7:0]        adr_i,                  // byte address
    input  wire [3:0]        sel_i,                  // byte selects
    input  wire [31:0]       dat_i,                  // write data
    output reg  [31:0]       dat_o,                  // read data
    output reg               ack_o,                  // acknowledge
    // strap and configuration pins
    input  wire              config_link_enable_pin, // strap override
    input  wire              width_strap_pin,        // bus width strap
    input  wire              sync_strap_pin,         // sync encoding strap
    input  wire              coding_strap_pin,       // error coding strap
    input  wire              double_strap_pin,       // double input strap
    input  wire              config_pin_high,        // config input 1
    input  wire              config_pin_low,         // config input 0
    // parallel pixel input
    input  wire              pixel_clock_input,      // pixel clock pin
    input  wire [DATA_W-1:0] parallel_input_i,       // pixel data pins
    input  wire              horizontal_sync_i,      // hsync pin
    input  wire              vertical_sync_i,        // vsync pin
    // configuration state
    output wire              double_input_mode_o,    // 1 = double input
    output wire              low_rate_o,             // 1 = low data rate
    output wire              bus_width_select_o,     // 1 = 32-bit input
    output wire              capture_edge_select_o,  // 1 = falling edge
    output wire              sync_encoding_enable_o, // 1 = sync encoded
    output wire [1:0]        error_coding_select_o,  // coding scheme
    // captured and coded word
    output reg  [DATA_W+1:0] word_o,                 // {vs, hs, data}
    output reg  [5:0]        check_o,                // check bits
    output reg  [3:0]        interleave_slot_o,      // hamming slot
    output reg               word_valid_o            // one-cycle pulse
);

    localparam         PIN_W    = DATA_W + 10;
    localparam integer ILV_N    = `SICC_ILV_WORDS - 1;
    localparam [4:0]   ILV_LAST = ILV_N[4:0];
    localparam [7:0]   INV_RST  = `SICC_INV_RESET;

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    wire [PIN_W-1:0] pins_sync;
    wire             pclk_s;
    wire [DATA_W-1:0] din_s;
    wire             hsync_s;
    wire             vsync_s;
    wire             lcc_s;
    wire             wide_s;
    wire             senc_s;
    wire             code_s;
    wire             dual_s;
    wire             cfg_hi_s;
    wire             cfg_lo_s;

    sicc_pin_sync #(
        .WIDTH (PIN_W)
    ) u_sync (
        .clk_i  (clk_i),
        .pin_i  ({pixel_clock_input, parallel_input_i, horizontal_sync_i,
                  vertical_sync_i, config_link_enable_pin, width_strap_pin,
                  sync_strap_pin, coding_strap_pin, double_strap_pin,
                  config_pin_high, config_pin_low}),
        .sync_o (pins_sync)
    );

    assign pclk_s  = pins_sync[PIN_W-1];
    assign din_s   = pins_sync[PIN_W-2:9];
    assign hsync_s  = pins_sync[8];
    assign vsync_s  = pins_sync[7];
    assign lcc_s    = pins_sync[6];
    assign wide_s   = pins_sync[5];
    assign senc_s   = pins_sync[4];
    assign code_s   = pins_sync[3];
    assign dual_s   = pins_sync[2];
    assign cfg_hi_s = pins_sync[1];
    assign cfg_lo_s = pins_sync[0];

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    reg        dual_reg;
    reg        rate_reg;
    reg        wide_reg;
    reg        edge_reg;
    reg        senc_reg;
    reg [1:0]  code_reg;
    reg        inv_vsync_reg;
    reg        inv_hsync_reg;

    wire       bus_req;
    wire       bus_wr;
    wire [3:0] reg_idx;
    wire [7:0] fmt_rd;
    wire [7:0] inv_rd;
    wire [1:0] code_wr;
    wire       edge_dec;

    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign bus_wr  = bus_req & we_i & sel_i[0];
    assign reg_idx = adr_i[`SICC_ADR_MSB:`SICC_ADR_LSB];
    assign code_wr = dat_i[`SICC_FMT_CODE_MSB:`SICC_FMT_CODE_LSB];

    // edge default follows config input 0; config input 1 cancels out of the decode
    assign edge_dec = cfg_lo_s & ~cfg_hi_s | cfg_lo_s & cfg_hi_s;

    // synchronous reset loads strap-derived defaults from synced pins
    always @(posedge clk_i) begin
        if (rst_i) begin
            dual_reg      <= ~lcc_s & dual_s;
            rate_reg      <= `SICC_RATE_RESET;
            wide_reg      <= ~lcc_s & wide_s;
            edge_reg      <= edge_dec;
            senc_reg      <= ~lcc_s & senc_s;
            code_reg      <= (~lcc_s & code_s) ? `SICC_CODE_HAMMING
                                               : `SICC_CODE_PARITY;
            inv_vsync_reg <= INV_RST[`SICC_INV_VSYNC_BIT];
            inv_hsync_reg <= INV_RST[`SICC_INV_HSYNC_BIT];
        end else if (bus_wr) begin
            if (reg_idx == `SICC_IDX_FMT) begin
                dual_reg <= dat_i[`SICC_FMT_DUAL_BIT];
                rate_reg <= dat_i[`SICC_FMT_RATE_BIT];
                wide_reg <= dat_i[`SICC_FMT_WIDE_BIT];
                edge_reg <= dat_i[`SICC_FMT_EDGE_BIT];
                senc_reg <= dat_i[`SICC_FMT_SENC_BIT];
                if (code_wr != `SICC_CODE_UNUSED) begin
                    code_reg <= code_wr;
                end
            end
            if (reg_idx == `SICC_IDX_INV) begin
                inv_vsync_reg <= dat_i[`SICC_INV_VSYNC_BIT];
                inv_hsync_reg <= dat_i[`SICC_INV_HSYNC_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // wishbone read and acknowledge
    // ------------------------------------------------------------
    assign fmt_rd = {dual_reg, rate_reg, wide_reg, edge_reg, 1'b0,
                     senc_reg, code_reg};
    assign inv_rd = {inv_vsync_reg, inv_hsync_reg, 6'h00};

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req;
            if (bus_req & ~we_i) begin
                case (reg_idx)
                    `SICC_IDX_FMT: begin
                        dat_o <= {24'h00_0000, fmt_rd};
                    end
                    `SICC_IDX_INV: begin
                        dat_o <= {24'h00_0000, inv_rd};
                    end
                    default: begin
                        dat_o <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    assign double_input_mode_o    = dual_reg;
    assign low_rate_o             = rate_reg;
    assign bus_width_select_o     = wide_reg;
    assign capture_edge_select_o  = edge_reg;
    assign sync_encoding_enable_o = senc_reg;
    assign error_coding_select_o  = code_reg;

    // ------------------------------------------------------------
    // pixel clock edge detection
    // ------------------------------------------------------------
    reg  pclk_d_reg;
    wire rise;
    wire fall;
    wire take;

    always @(posedge clk_i) begin
        if (rst_i) begin
            pclk_d_reg <= 1'b0;
        end else begin
            pclk_d_reg <= pclk_s;
        end
    end

    assign rise = pclk_s & ~pclk_d_reg;
    assign fall = ~pclk_s & pclk_d_reg;
    // edge select is expected stable while the pixel clock runs
    assign take = edge_reg ? fall : rise;

    // ------------------------------------------------------------
    // input formatting: width mask, sync encoding and inversion
    // ------------------------------------------------------------
    reg [DATA_W-1:0] data_fmt;
    reg              hsync_fmt;
    reg              vsync_fmt;

    always @* begin
        data_fmt  = din_s;
        hsync_fmt = 1'b0;
        vsync_fmt = 1'b0;
        if (!wide_reg) begin
            data_fmt[DATA_W-1:24] = {(DATA_W-24){1'b0}};
        end
        if (senc_reg) begin
            hsync_fmt = hsync_s ^ inv_hsync_reg;
            vsync_fmt = vsync_s ^ inv_vsync_reg;
        end else begin
            data_fmt[0] = din_s[0] ^ inv_vsync_reg;
            data_fmt[1] = din_s[1] ^ inv_hsync_reg;
        end
    end

    // ------------------------------------------------------------
    // check bit generation and word output
    // ------------------------------------------------------------
    wire [DATA_W+1:0] word_next;
    wire [5:0]        check_next;
    reg  [4:0]        slot_reg;

    assign word_next = {vsync_fmt, hsync_fmt, data_fmt};

    sicc_check_gen #(
        .WIDTH (DATA_W + 2)
    ) u_check (
        .word_i  (word_next),
        .mode_i  (code_reg),
        .check_o (check_next)
    );

    always @(posedge clk_i) begin
        if (rst_i) begin
            word_o            <= {(DATA_W+2){1'b0}};
            check_o           <= 6'h00;
            interleave_slot_o <= 4'h0;
            word_valid_o      <= 1'b0;
            slot_reg          <= 5'h00;
        end else begin
            word_valid_o <= take;
            if (take) begin
                word_o  <= word_next;
                check_o <= check_next;
                // outside hamming mode the slot reads zero, even after a mode switch
                if (code_reg == `SICC_CODE_HAMMING) begin
                    interleave_slot_o <= slot_reg[3:0];
                    slot_reg <= (slot_reg == ILV_LAST) ? 5'h00
                                                       : slot_reg + 5'h01;
                end else begin
                    interleave_slot_o <= 4'h0;
                    slot_reg <= 5'h00;
                end
            end
        end
    end

endmodule

`default_nettype wire
